// ==== rtl/isagg_consts.svh ====
// constants for the interrupt source aggregator: node numbers, counts
// assumes nothing beyond a SystemVerilog compiler
`ifndef ISAGG_CONSTS_SVH
`define ISAGG_CONSTS_SVH

`define ISAGG_NODE_CNT      24
`define ISAGG_NODE_CCU0     4
`define ISAGG_NODE_SER0     8
`define ISAGG_NODE_SER1     9
`define ISAGG_NODE_UART0    10
`define ISAGG_NODE_UART1    11
`define ISAGG_NODE_EXT0     12
`define ISAGG_NODE_EXT1     13
`define ISAGG_NODE_WAKE     14
`define ISAGG_NODE_DIV      15
`define ISAGG_NODE_PUMP     17
`define ISAGG_NODE_BRIDGE   18
`define ISAGG_NODE_SWITCH   19
`define ISAGG_NODE_SENSE    20
`define ISAGG_NODE_DIFF     21
`define ISAGG_NODE_MON      22
`define ISAGG_NODE_PORT     23
`define ISAGG_PULSE_CYC     2
`define ISAGG_CCU_EVENTS    4
`define ISAGG_PUMP_SRC      7
`define ISAGG_BRIDGE_SRC    9
`define ISAGG_SWITCH_SRC    3
`define ISAGG_MON_SRC       16
`define ISAGG_PORT_SRC      16
`define ISAGG_UART0_SRC     12
`define ISAGG_UART1_SRC     8

`endif

// ==== rtl/isagg_pkg.sv ====
// types for the interrupt source aggregator
// assumes the constants header is on the include path
package isagg_pkg;
    `include "isagg_consts.svh"
    typedef logic [`ISAGG_NODE_CNT-1:0] isagg_node_t;
    typedef logic [1:0]                 isagg_ptr_t;
    typedef enum logic {ISAGG_LEVEL, ISAGG_EDGE} isagg_kind_e;
endpackage

// ==== rtl/isagg_src_if.sv ====
// bundle between the aggregator top and its sticky flag bank
// assumes one clock domain, mclk
`timescale 1ns/1ps
interface isagg_src_if #(parameter int N = 8);
    logic [N-1:0] event_in;
    logic [N-1:0] clear;
    logic [N-1:0] flag;
    modport bank (input event_in, input clear, output flag);
    modport user (output event_in, output clear, input flag);
endinterface

// ==== rtl/isagg_flag_bank.sv ====
// bank of sticky status flags, edge or level sensitive per bit
// assumes event inputs synchronous to mclk
`timescale 1ns/1ps
module isagg_flag_bank #(
    parameter int                    N       = 8,
    parameter logic [N-1:0]          IS_EDGE = '0
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // sources and flags
    isagg_src_if.bank src
);
    import isagg_pkg::*;

    logic [N-1:0] prev;
    logic [N-1:0] hit;

    // refuse an empty bank while elaborating
    if (N < 1) begin : g_bad_width
        $error("flag bank needs at least one source");
    end

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            // edge sources catch a single rising-edge cycle
            assign hit[i] = IS_EDGE[i] ? (src.event_in[i] & ~prev[i])
                                       : src.event_in[i];
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    prev[i]     <= 1'b0;
                    src.flag[i] <= 1'b0;
                end else begin
                    prev[i] <= src.event_in[i];
                    // set wins over a clear in the same cycle
                    if (hit[i])
                        src.flag[i] <= 1'b1;
                    else if (src.clear[i])
                        src.flag[i] <= 1'b0;
                end
            end
        end
    endgenerate

    a_flag_sticky : assert property (@(posedge mclk) disable iff (!rst_n)
        (|(src.flag & ~src.clear)) |=>
        (|src.flag)) else $error("sticky flag lost without clear");
endmodule

// ==== rtl/isagg_top.sv ====
// interrupt source aggregator: event flags and enables to request nodes
// assumes all inputs synchronous to mclk; clear inputs are one-cycle
// software clear strobes from the owning register block
//
// Contract
// - capture/compare lines drive nodes 4-7, 2-cycle
// - any capture/compare event routes via node pointer
// - serial channels nodes 8/9, three 2-cycle requests
// - UART receive flag copied onto node 10/11
// - UART transmit flag copied onto node 10/11
// - sync byte error/end share one enable
// - timer overflow/external flags edge, nodes 10/11
// - transceiver faults set own and shared fail
// - tx line timeout, mode error edge node 10
// - third pin rise/fall flags on node 11
// - first, second pins on nodes 12, 13
// - wake-up edge flag on node 14
// - divider error and done on node 15
// - charge pump seven edge sources node 17
// - bridge overcurrents level sources node 18
// - bridge drain monitors edge sources node 18
// - bridge sequence error level node 18
// - switch overcurrent, overtemp, open load node 19
// - sense amp thresholds edge on node 20
// - diff unit thresholds edge on node 21
// - monitor wakes and thresholds on node 22
// - port thresholds edge on node 23
// - disabled source never requests; node enables
`timescale 1ns/1ps
module isagg_top
    import isagg_pkg::*;
(
    // clock and reset
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    // capture/compare events, enables and node pointers
    input  wire logic [3:0]                ccu_event,
    input  wire logic [3:0]                ccu_event_en,
    input  wire logic [7:0]                node_pointer_regs,
    // synchronous serial channels: error, tx, rx per channel
    input  wire logic [2:0]                serial0_event,
    input  wire logic [2:0]                serial0_en,
    input  wire logic [2:0]                serial1_event,
    input  wire logic [2:0]                serial1_en,
    // uarts: flags kept by the uart, mirrored here
    input  wire logic [1:0]                receive_complete_flag,
    input  wire logic [1:0]                receive_en,
    input  wire logic [1:0]                transmit_complete_flag,
    input  wire logic [1:0]                transmit_en,
    // uart0 line events and enables, timers for both uarts
    input  wire logic                      sync_error_event,
    input  wire logic                      sync_end_event,
    input  wire logic                      sync_irq_enable,
    input  wire logic [1:0]                timer_overflow_event,
    input  wire logic [1:0]                timer_overflow_en,
    input  wire logic [1:0]                timer_external_event,
    input  wire logic [1:0]                timer_external_en,
    input  wire logic                      lin_overtemp_event,
    input  wire logic                      lin_overtemp_en,
    input  wire logic                      lin_overcurrent_event,
    input  wire logic                      lin_overcurrent_en,
    input  wire logic                      tx_line_timeout,
    input  wire logic                      tx_line_timeout_en,
    input  wire logic                      mode_machine_error,
    input  wire logic                      mode_machine_error_en,
    // external pins 0..2 and wake-up
    input  wire logic [2:0]                ext_pin,
    input  wire logic [2:0]                ext_pin_en,
    input  wire logic                      wake_event,
    input  wire logic                      wake_en,
    // divider: bit0 error, bit1 done
    input  wire logic [1:0]                divide_event,
    input  wire logic [1:0]                divide_en,
    // analog supervision sub-sources and their enables
    input  wire logic [6:0]                pump_event,
    input  wire logic [6:0]                pump_en,
    input  wire logic [8:0]                bridge_event,
    input  wire logic [8:0]                bridge_en,
    input  wire logic [2:0]                switch_event,
    input  wire logic [2:0]                switch_en,
    input  wire logic [1:0]                sense_amp_event,
    input  wire logic [1:0]                sense_amp_en,
    input  wire logic [1:0]                diff_unit_event,
    input  wire logic [1:0]                diff_unit_en,
    input  wire logic [3:0]                monitor_level,
    input  wire logic [3:0]                monitor_en,
    input  wire logic [7:0]                monitor_thresh_event,
    input  wire logic [7:0]                monitor_thresh_en,
    input  wire logic [15:0]               port_thresh_event,
    input  wire logic [15:0]               port_thresh_en,
    // software clears, one-cycle strobes per flag group
    input  wire logic [11:0]               uart0_clear,
    input  wire logic [7:0]                uart1_clear,
    input  wire logic [1:0]                ext01_clear,
    input  wire logic [2:0]                misc_clear,
    input  wire logic [6:0]                pump_clear,
    input  wire logic [8:0]                bridge_clear,
    input  wire logic [2:0]                switch_clear,
    input  wire logic [3:0]                analog_clear,
    input  wire logic [15:0]               monitor_clear,
    input  wire logic [15:0]               port_clear,
    input  wire logic                      fail_clear,
    // node-wide enables
    input  wire isagg_pkg::isagg_node_t    node_en,
    // requests and status
    output isagg_pkg::isagg_node_t         node_req,
    output logic                           transceiver_fail_flag,
    output logic [11:0]                    uart0_status,
    output logic [7:0]                     uart1_status
);
    import isagg_pkg::*;

    // ******************************************************
    // short pulse stretch for the 2-cycle level nodes
    // ******************************************************
    logic [3:0] ccu_route;
    logic [5:0] ser_evt;
    logic [5:0] ser_en;
    logic [9:0] pulse_in;
    logic [9:0] pulse_d;
    logic [9:0] pulse_q;

    // each event lands on the node its pointer names
    genvar n;
    generate
        for (n = 0; n < 4; n++) begin : g_route
            assign ccu_route[n] =
                |{ccu_event[0] & ccu_event_en[0]
                     & (node_pointer_regs[1:0] == 2'(n)),
                  ccu_event[1] & ccu_event_en[1]
                     & (node_pointer_regs[3:2] == 2'(n)),
                  ccu_event[2] & ccu_event_en[2]
                     & (node_pointer_regs[5:4] == 2'(n)),
                  ccu_event[3] & ccu_event_en[3]
                     & (node_pointer_regs[7:6] == 2'(n))};
        end
    endgenerate

    assign ser_evt  = {serial1_event, serial0_event};
    assign ser_en   = {serial1_en, serial0_en};
    assign pulse_in = {ser_evt & ser_en, ccu_route};

    // a request lasts the event cycle plus one more
    always_ff @(posedge mclk) begin
        if (!rst_n)
            pulse_d <= '0;
        else
            pulse_d <= pulse_in;
    end
    assign pulse_q = pulse_in | pulse_d;

    // ******************************************************
    // sticky flag banks
    // ******************************************************
    // uart0: 0 sync err, 1 sync end, 2 ovf, 3 ext, 4 lin ot, 5 lin oc,
    // 6 timeout, 7 mode err, 8..11 spare kept zero
    isagg_src_if #(.N(`ISAGG_UART0_SRC)) u0_if ();
    isagg_src_if #(.N(`ISAGG_UART1_SRC)) u1_if ();
    isagg_src_if #(.N(2))                 e_if ();
    isagg_src_if #(.N(3))                 m_if ();
    isagg_src_if #(.N(`ISAGG_PUMP_SRC))   p_if ();
    isagg_src_if #(.N(`ISAGG_BRIDGE_SRC)) b_if ();
    isagg_src_if #(.N(`ISAGG_SWITCH_SRC)) s_if ();
    isagg_src_if #(.N(4))                 a_if ();
    isagg_src_if #(.N(`ISAGG_MON_SRC))    mo_if ();
    isagg_src_if #(.N(`ISAGG_PORT_SRC))   po_if ();
    logic [2:0] ext_pin_q;
    logic [3:0] mon_q;

    // sync flags are level, timer/ot/timeout/mode are edge
    assign u0_if.event_in = {4'h0, mode_machine_error, tx_line_timeout,
        lin_overcurrent_event, lin_overtemp_event,
        timer_external_event[0], timer_overflow_event[0],
        sync_end_event, sync_error_event};
    assign u0_if.clear    = uart0_clear;
    // uart1: 0 ovf, 1 ext, 2..3 pin2 rise/fall, 4..7 spare
    assign u1_if.event_in = {4'h0, ~ext_pin[2] & ext_pin_q[2],
        ext_pin[2] & ~ext_pin_q[2],
        timer_external_event[1], timer_overflow_event[1]};
    assign u1_if.clear    = uart1_clear;
    // pins 0,1: one flag each, either edge
    assign e_if.event_in  = ext_pin[1:0] ^ ext_pin_q[1:0];
    assign e_if.clear     = ext01_clear;
    assign m_if.event_in  = {divide_event, wake_event};
    assign m_if.clear     = misc_clear;
    assign p_if.event_in  = pump_event;
    assign p_if.clear     = pump_clear;
    assign b_if.event_in  = bridge_event;
    assign b_if.clear     = bridge_clear;
    assign s_if.event_in  = switch_event;
    assign s_if.clear     = switch_clear;
    assign a_if.event_in  = {diff_unit_event, sense_amp_event};
    assign a_if.clear     = analog_clear;
    // monitors: 0..3 rise, 4..7 fall, 8..15 threshold compares
    assign mo_if.event_in = {monitor_thresh_event,
        ~monitor_level & mon_q, monitor_level & ~mon_q};
    assign mo_if.clear    = monitor_clear;
    assign po_if.event_in = port_thresh_event;
    assign po_if.clear    = port_clear;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ext_pin_q <= '0;
            mon_q     <= '0;
        end else begin
            ext_pin_q <= ext_pin;
            mon_q     <= monitor_level;
        end
    end

    isagg_flag_bank #(.N(`ISAGG_UART0_SRC), .IS_EDGE(12'h0DC)) u_u0 (
        .mclk(mclk), .rst_n(rst_n), .src(u0_if.bank));
    isagg_flag_bank #(.N(`ISAGG_UART1_SRC), .IS_EDGE(8'h03)) u_u1 (
        .mclk(mclk), .rst_n(rst_n), .src(u1_if.bank));
    isagg_flag_bank #(.N(2), .IS_EDGE(2'h0)) u_e (
        .mclk(mclk), .rst_n(rst_n), .src(e_if.bank));
    isagg_flag_bank #(.N(3), .IS_EDGE(3'h1)) u_m (
        .mclk(mclk), .rst_n(rst_n), .src(m_if.bank));
    // pump sources are all edge
    isagg_flag_bank #(.N(`ISAGG_PUMP_SRC), .IS_EDGE(7'h7F)) u_p (
        .mclk(mclk), .rst_n(rst_n), .src(p_if.bank));
    // 0..3 overcurrent level, 4..7 drain edge, 8 sequence level
    isagg_flag_bank #(.N(`ISAGG_BRIDGE_SRC), .IS_EDGE(9'h0F0)) u_b (
        .mclk(mclk), .rst_n(rst_n), .src(b_if.bank));
    isagg_flag_bank #(.N(`ISAGG_SWITCH_SRC), .IS_EDGE(3'h6)) u_s (
        .mclk(mclk), .rst_n(rst_n), .src(s_if.bank));
    isagg_flag_bank #(.N(4), .IS_EDGE(4'hF)) u_a (
        .mclk(mclk), .rst_n(rst_n), .src(a_if.bank));
    isagg_flag_bank #(.N(`ISAGG_MON_SRC), .IS_EDGE(16'hFF00)) u_mo (
        .mclk(mclk), .rst_n(rst_n), .src(mo_if.bank));
    isagg_flag_bank #(.N(`ISAGG_PORT_SRC), .IS_EDGE(16'hFFFF)) u_po (
        .mclk(mclk), .rst_n(rst_n), .src(po_if.bank));

    // ******************************************************
    // per-node gating and or
    // ******************************************************
    logic [11:0] u0_en;
    logic [7:0]  u1_en;
    logic [15:0] mo_en;
    isagg_node_t raw_req;
    isagg_node_t next_req;

    assign u0_en = {4'h0, mode_machine_error_en, tx_line_timeout_en,
        lin_overcurrent_en, lin_overtemp_en, timer_external_en[0],
        timer_overflow_en[0], sync_irq_enable, sync_irq_enable};
    assign u1_en = {4'h0, ext_pin_en[2], ext_pin_en[2],
        timer_external_en[1], timer_overflow_en[1]};
    assign mo_en = {monitor_thresh_en, monitor_en, monitor_en};

    // uart flags are mirrored as levels, never stored here
    // they stay set until software clears them in the uart
    assign raw_req[3:0]  = '0;
    assign raw_req[7:4]  = pulse_q[3:0];
    assign raw_req[8]    = |pulse_q[6:4];
    assign raw_req[9]    = |pulse_q[9:7];
    assign raw_req[10]   = |(u0_if.flag & u0_en)
        | (receive_complete_flag[0] & receive_en[0])
        | (transmit_complete_flag[0] & transmit_en[0]);
    assign raw_req[11]   = |(u1_if.flag & u1_en)
        | (receive_complete_flag[1] & receive_en[1])
        | (transmit_complete_flag[1] & transmit_en[1]);
    assign raw_req[12]   = e_if.flag[0] & ext_pin_en[0];
    assign raw_req[13]   = e_if.flag[1] & ext_pin_en[1];
    assign raw_req[14]   = m_if.flag[0] & wake_en;
    assign raw_req[15]   = |(m_if.flag[2:1] & divide_en);
    assign raw_req[16]   = 1'b0;
    assign raw_req[17]   = |(p_if.flag & pump_en);
    assign raw_req[18]   = |(b_if.flag & bridge_en);
    assign raw_req[19]   = |(s_if.flag & switch_en);
    assign raw_req[20]   = |(a_if.flag[1:0] & sense_amp_en);
    assign raw_req[21]   = |(a_if.flag[3:2] & diff_unit_en);
    // threshold compares latch like the wake edges, so a one-cycle
    // compare event is still pending when the core gets to it
    assign raw_req[22]   = |(mo_if.flag & mo_en);
    assign raw_req[23]   = |(po_if.flag & port_thresh_en);

    // node-wide enable masks every node
    assign next_req = raw_req & node_en;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            node_req              <= '0;
            transceiver_fail_flag <= 1'b0;
            uart0_status          <= '0;
            uart1_status          <= '0;
        end else begin
            node_req     <= next_req;
            uart0_status <= u0_if.flag;
            uart1_status <= u1_if.flag;
            // shared fail flag: set beats clear
            if (u0_if.event_in[4] | u0_if.event_in[5])
                transceiver_fail_flag <= 1'b1;
            else if (fail_clear)
                transceiver_fail_flag <= 1'b0;
        end
    end

    // ******************************************************
    // checks
    // ******************************************************
    sequence s_ccu_hit;
        ccu_event[0] && ccu_event_en[0] && node_pointer_regs[1:0] == 2'd0
        && node_en[4];
    endsequence

    a_ccu_route_len : assert property (@(posedge mclk) disable iff (!rst_n)
        s_ccu_hit |=> node_req[4] [*2]) else $error("ccu node pulse short");
    a_ccu_ptr_sel : assert property (@(posedge mclk) disable iff (!rst_n)
        (ccu_event[1] && ccu_event_en[1] && node_pointer_regs[3:2] == 2'd3
         && node_en[7]) |=> node_req[7]) else $error("ccu pointer route");
    a_ser_pulse : assert property (@(posedge mclk) disable iff (!rst_n)
        (serial0_event[2] && serial0_en[2] && node_en[8]) |=> node_req[8] [*2])
        else $error("serial request short");
    a_uart_mirror : assert property (@(posedge mclk) disable iff (!rst_n)
        (receive_complete_flag[0] && receive_en[0] && node_en[10])
        |=> node_req[10]) else $error("uart rx not mirrored");
    a_uart_tx : assert property (@(posedge mclk) disable iff (!rst_n)
        (transmit_complete_flag[1] && transmit_en[1] && node_en[11])
        |=> node_req[11]) else $error("uart tx not mirrored");
    a_node_mask : assert property (@(posedge mclk) disable iff (!rst_n)
        !node_en[17] |=> !node_req[17]) else $error("masked node requests");
    a_wake_edge : assert property (@(posedge mclk) disable iff (!rst_n)
        ($rose(wake_event) && wake_en && node_en[14]
         && !misc_clear[0]) |=> ##1 node_req[14]) else $error("wake lost");
    a_fail_set : assert property (@(posedge mclk) disable iff (!rst_n)
        (lin_overcurrent_event) |=> transceiver_fail_flag)
        else $error("fail flag not set");
    a_ext2_rise : assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(ext_pin[2]) |=> u1_if.flag[2])
        else $error("pin2 rise flag not set");
    a_div_done : assert property (@(posedge mclk) disable iff (!rst_n)
        (divide_event[1] && divide_en[1] && node_en[15]) |=> ##1 node_req[15])
        else $error("divider done not requested");

    sequence s_mon_up_set;
        $rose(monitor_thresh_event[0]) ##1 !monitor_clear[8];
    endsequence

    a_mon_thresh_hold : assert property (@(posedge mclk)
        disable iff (!rst_n) s_mon_up_set |=> mo_if.flag[8])
        else $error("monitor threshold flag lost");
endmodule

// ==== test/isagg_core_model.sv ====
// processor core side: records which request nodes it has taken
// assumes node_req is registered in the mclk domain
`timescale 1ns/1ps
module isagg_core_model
    import isagg_pkg::*;
(
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // requests in, taken requests out
    input  wire isagg_pkg::isagg_node_t node_req,
    input  wire logic               seen_clr,
    output isagg_pkg::isagg_node_t  seen
);
    // taking a request never touches the source flags, so the bench can
    // see that a serviced request stays up until its flag is cleared
    always_ff @(posedge mclk) begin
        if (!rst_n || seen_clr) begin
            seen <= '0;
        end else begin
            seen <= seen | node_req;
        end
    end
endmodule

// ==== test/test_interrupt_source_aggregator.sv ====
// self-checking bench for the interrupt source aggregator
// assumes the package, interface and design files are compiled first
`timescale 1ns/1ps
module test_interrupt_source_aggregator;
    import isagg_pkg::*;
    // ************************************************
    // stimulus vectors: one bit per source, same index for enables except sync end, which uses en[14]
    // ************************************************
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        seen_clr = 1'b0;
    logic [80:0] ev = '0;
    logic [80:0] en = '0;
    logic [80:0] clr = '0;
    logic [7:0]  ptr = '0;
    isagg_node_t ne = '1;
    isagg_node_t req;
    isagg_node_t seen;
    logic        fail;
    logic [11:0] u0s;
    logic [7:0]  u1s;
    int          err_count = 0;
    int          checks_done = 0;
    always #2.5 mclk = ~mclk;
    isagg_top isagg_top_inst (.mclk(mclk), .rst_n(rst_n),
        .ccu_event(ev[3:0]), .ccu_event_en(en[3:0]), .node_pointer_regs(ptr),
        .serial0_event(ev[6:4]), .serial0_en(en[6:4]),
        .serial1_event(ev[9:7]), .serial1_en(en[9:7]),
        .receive_complete_flag(ev[11:10]), .receive_en(en[11:10]),
        .transmit_complete_flag(ev[13:12]), .transmit_en(en[13:12]),
        .sync_error_event(ev[14]), .sync_end_event(ev[15]),
        .sync_irq_enable(en[14]), .timer_overflow_event(ev[17:16]),
        .timer_overflow_en(en[17:16]), .timer_external_event(ev[19:18]),
        .timer_external_en(en[19:18]), .lin_overtemp_event(ev[20]),
        .lin_overtemp_en(en[20]), .lin_overcurrent_event(ev[21]),
        .lin_overcurrent_en(en[21]), .tx_line_timeout(ev[22]),
        .tx_line_timeout_en(en[22]), .mode_machine_error(ev[23]),
        .mode_machine_error_en(en[23]), .ext_pin(ev[26:24]),
        .ext_pin_en(en[26:24]), .wake_event(ev[27]), .wake_en(en[27]),
        .divide_event(ev[29:28]), .divide_en(en[29:28]),
        .pump_event(ev[36:30]), .pump_en(en[36:30]),
        .bridge_event(ev[45:37]), .bridge_en(en[45:37]),
        .switch_event(ev[48:46]), .switch_en(en[48:46]),
        .sense_amp_event(ev[50:49]), .sense_amp_en(en[50:49]),
        .diff_unit_event(ev[52:51]), .diff_unit_en(en[52:51]),
        .monitor_level(ev[56:53]), .monitor_en(en[56:53]),
        .monitor_thresh_event(ev[64:57]), .monitor_thresh_en(en[64:57]),
        .port_thresh_event(ev[80:65]), .port_thresh_en(en[80:65]),
        .uart0_clear(clr[11:0]), .uart1_clear(clr[19:12]),
        .ext01_clear(clr[21:20]), .misc_clear(clr[24:22]),
        .pump_clear(clr[31:25]), .bridge_clear(clr[40:32]),
        .switch_clear(clr[43:41]), .analog_clear(clr[47:44]),
        .monitor_clear(clr[63:48]), .port_clear(clr[79:64]),
        .fail_clear(clr[80]), .node_en(ne), .node_req(req),
        .transceiver_fail_flag(fail), .uart0_status(u0s),
        .uart1_status(u1s));
    isagg_core_model isagg_core_model_inst (.mclk(mclk), .rst_n(rst_n),
        .node_req(req), .seen_clr(seen_clr), .seen(seen));
    // ************************************************
    // reference model and helpers
    // ************************************************
    task automatic chk(logic [23:0] got, logic [23:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    function automatic int node_of(int k);
        if (k inside {17, 19, 26}) return 11;
        if (k < 24) return 10;
        if (k < 27) return k - 12;
        if (k == 27) return 14;
        if (k < 30) return 15;
        if (k < 37) return 17;
        if (k < 46) return 18;
        if (k < 49) return 19;
        if (k < 51) return 20;
        if (k < 53) return 21;
        if (k < 65) return 22;
        return 23;
    endfunction
    function automatic logic [80:0] clr_of(int k);
        logic [80:0] m;
        m = '0;
        case (k)
            16: m[2] = 1'b1;
            17: m[12] = 1'b1;
            18: m[3] = 1'b1;
            19: m[13] = 1'b1;
            24: m[20] = 1'b1;
            25: m[21] = 1'b1;
            26: m[15:14] = 2'h3;
            default: m[k < 16 ? k - 14 : (k < 24 ? k - 16
                       : (k < 57 ? k - 5 : k - 1))] = 1'b1;
        endcase
        if (k inside {[53:56]}) m[k - 1] = 1'b1;
        if (k inside {20, 21}) m[80] = 1'b1;
        return m;
    endfunction
    // level sources keep setting their flag while the condition holds
    function automatic bit is_lvl(int k);
        return k inside {14, 15, 21, 28, 29, [37:40], 45, 46};
    endfunction
    task automatic strobe(logic [80:0] m);
        @(posedge mclk);
        clr <= m;
        @(posedge mclk);
        clr <= '0;
    endtask
    // one sticky source: set, serviced, cleared while held, then released
    task automatic sticky(int k, bit on, bit non);
        int          n;
        isagg_node_t exp;
        logic [80:0] cm;
        n = node_of(k);
        cm = clr_of(k);
        exp = isagg_node_t'(on & non) << n;
        @(posedge mclk);
        en <= '0;
        en[k] <= on;
        if (k == 15) en[14] <= on;
        ne <= '1;
        ne[n] <= non;
        ev[k] <= 1'b1;
        seen_clr <= 1'b1;
        @(posedge mclk);
        seen_clr <= 1'b0;
        tick(2);
        chk(req, exp);
        chk(seen, exp);
        chk(24'({u1s, u0s}), 24'(cm[19:0] & 20'h7FFF));
        if (k inside {20, 21}) chk(24'(fail), 24'h1);
        strobe(cm);
        tick(3);
        chk(req, is_lvl(k) ? exp : '0);
        @(posedge mclk);
        ev[k] <= 1'b0;
        tick(2);
        strobe(cm);
        tick(3);
        chk(req, '0);
        chk(24'(fail), 24'h0);
        chk(24'({u1s, u0s}), 24'h0);
    endtask
    // one-cycle event must give exactly two request cycles on node n only when enabled, none when not
    task automatic pulse(int k, int n, bit on);
        int          cnt;
        isagg_node_t other;
        cnt = 0;
        other = '0;
        @(posedge mclk);
        en[k] <= on;
        ev[k] <= 1'b1;
        @(posedge mclk);
        ev[k] <= 1'b0;
        repeat (6) begin
            #1;
            cnt += int'(req[n] === 1'b1);
            other |= req & ~(isagg_node_t'(1) << n);
            @(posedge mclk);
        end
        chk(24'(cnt), on ? 24'd2 : 24'd0);
        chk(other, '0);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ************************************************
    // main sequence
    // ************************************************
    initial begin
        logic [7:0] p;
        void'($urandom(32'h4dd4));
        tick(3);
        chk(req, '0);
        @(posedge mclk);
        rst_n <= 1'b1;
        for (int r = 0; r < 12; r++) begin
            p = 8'($urandom);
            ptr <= p;
            pulse(r % 4, 4 + int'(p[2 * (r % 4) +: 2]), r < 8);
        end
        for (int k = 4; k < 10; k++) pulse(k, 8 + int'(k > 6), 1'b1);
        for (int k = 10; k < 14; k++) begin
            @(posedge mclk);
            en[k] <= k != 12;
            ev[k] <= 1'b1;
            tick(3);
            chk(req, isagg_node_t'(k != 12) << (10 + k % 2));
            @(posedge mclk);
            ev[k] <= 1'b0;
            tick(3);
            chk(req, '0);
        end
        for (int s = 0; s < 2; s++) begin
            for (int k = 14; k < 81; k++) begin
                sticky(k, s == 0 || $urandom_range(3) != 0,
                       s == 0 || $urandom_range(3) != 0);
            end
        end
        complete_run();
    end
endmodule
